// ===== rtl/even_parity.sv
// Purpose: XOR reduction used for PCI even parity.
// Assumes: Purely combinational, read by registered logic only.
// Notes:   Result is one when the count of ones is odd.
`timescale 1ns/100ps
module even_parity #(
    parameter int W = 36
) (
    input  wire logic [W-1:0] bits,
    output logic              odd
);

    assign odd = ^bits;

endmodule : even_parity

// ===== rtl/pci_sec_pkg.sv
// Purpose: Shared constants and state types for the secondary bus port.
// Assumes: sys_clk is the secondary bus clock itself.
// Notes:   Pin-level values are active low where the bus says so.
package pci_sec_pkg;

    localparam int          AD_W                = 32;
    localparam int          CBE_W               = 4;
    localparam int          CNT_W               = 4;
    localparam int          CLK_PERIOD_NS       = 25;
    // Clocks from FRAME assertion allowed for a target to claim
    localparam int          DEVSEL_TIMEOUT_CLKS = 5;
    localparam int          CMD_WRITE_BIT       = 0;
    localparam logic [31:0] AD_RESET            = 32'h0000_0000;
    localparam logic [3:0]  CBE_RESET           = 4'h0;
    localparam logic        PAR_RESET           = 1'h0;
    localparam logic [31:0] AD_PARK             = 32'h0000_0000;
    localparam logic [3:0]  CBE_PARK            = 4'h0;
    localparam logic        DEASSERTED          = 1'h1;
    localparam logic        ASSERTED            = 1'h0;
    localparam logic        OE_DRIVE            = 1'h0;
    localparam logic        OE_FLOAT            = 1'h1;

    typedef enum logic [2:0] {M_IDLE, M_ADDR, M_DATA, M_LOAD, M_TURN} mst_state_e;
    typedef enum logic [2:0] {T_IDLE, T_DECODE, T_CLAIM, T_DATA, T_TURN} tgt_state_e;

endpackage : pci_sec_pkg

// ===== rtl/pci_secondary_bus_port.sv
// Purpose: Secondary PCI bus port: master engine, simple target, parking, parity.
// Assumes: sys_clk is the secondary clock input; bus pins are in its domain.
// Notes:   All pin outputs and enables are flip-flops; enables are active low.
//
// Overview of operation
// R1: FRAME start marks address; address captured then
// R2: Write data held stable while IRDY asserted
// R3: Word moves only when IRDY and TRDY
// R4: Idle with grant: drive AD lines
// R5: Command in address phase, byte enables after
// R6: Idle with grant: drive C/BE and PAR
// R7: PAR makes AD, C/BE, PAR even
// R8: Address parity checked one clock later
// R9: Write data parity checked one clock later
// R10: Read data PAR driven one clock later
// R11: PAR floats one clock after AD
// R12: FRAME held; deasserted marks final phase
// R13: Control driven deasserted one clock before float
// R14: IRDY/TRDY held until phase completes
// R15: No DEVSEL within 5 clocks: master abort
// R16: Target STOP makes initiator end transaction
// R17: LOCK asserted one clock after address
// R18: Locked secondary transactions never forwarded upstream
// R19: Reset floats control, drives zero data
// R20: Everything timed by secondary clock
// R21: Sample and change on rising edges
`timescale 1ns/100ps
module pci_secondary_bus_port
    import pci_sec_pkg::*;
#(
    parameter int TIMEOUT_CLKS = DEVSEL_TIMEOUT_CLKS
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic [AD_W-1:0]  secAddrDataIn,
    output logic      [AD_W-1:0]  secAddrDataOut,
    output logic                  secAddrDataOeN,
    input  wire logic [CBE_W-1:0] secCmdByteEnablesIn,
    output logic      [CBE_W-1:0] secCmdByteEnablesOut,
    output logic                  secCmdByteEnablesOeN,
    input  wire logic             secParityLineIn,
    output logic                  secParityLineOut,
    output logic                  secParityLineOeN,
    input  wire logic             secFrameNIn,
    output logic                  secFrameNOut,
    output logic                  secFrameNOeN,
    input  wire logic             secInitiatorReadyNIn,
    output logic                  secInitiatorReadyNOut,
    output logic                  secInitiatorReadyNOeN,
    input  wire logic             secTargetReadyNIn,
    output logic                  secTargetReadyNOut,
    output logic                  secTargetReadyNOeN,
    input  wire logic             secDeviceSelectNIn,
    output logic                  secDeviceSelectNOut,
    output logic                  secDeviceSelectNOeN,
    input  wire logic             secStopNIn,
    output logic                  secStopNOut,
    output logic                  secStopNOeN,
    input  wire logic             secLockNIn,
    output logic                  secLockNOut,
    output logic                  secLockNOeN,
    input  wire logic             busGrantN,
    input  wire logic             mstReq,
    input  wire logic             mstWrite,
    input  wire logic             mstLock,
    input  wire logic [CBE_W-1:0] mstCmd,
    input  wire logic [AD_W-1:0]  mstAddr,
    input  wire logic [AD_W-1:0]  mstWrData,
    input  wire logic [CBE_W-1:0] mstByteEn,
    input  wire logic             mstLast,
    output logic                  mstStart,
    output logic                  mstXfer,
    output logic      [AD_W-1:0]  mstRdData,
    output logic                  mstDone,
    output logic                  mstAbort,
    output logic                  mstStopped,
    output logic                  fwdValid,
    output logic      [AD_W-1:0]  fwdAddr,
    output logic      [CBE_W-1:0] fwdCmd,
    output logic                  fwdLockRefused,
    input  wire logic             tgtClaim,
    input  wire logic             tgtReady,
    input  wire logic [AD_W-1:0]  tgtRdData,
    output logic                  tgtWrValid,
    output logic      [AD_W-1:0]  tgtWrData,
    output logic      [CBE_W-1:0] tgtWrByteEn,
    output logic                  parErr
);

    ////////////////////////////////////////////////////////////////////////////
    // Bus view, sampled straight off the pins at each rising edge
    mst_state_e       mState_r, mNext;
    tgt_state_e       tState_r, tNext;
    logic             frameAct, irdyAct, trdyAct, devselAct, stopAct, lockAct;
    logic             grantAct, busIdle, xfer, addrPhase;
    logic             prevFrame_r, devselSeen_r, mWrite_r, mLock_r;
    logic [CNT_W-1:0] cnt_r;
    logic             mTake, mTimeout, mXfer, mRetry, mEnd;
    logic             trdyOn, tNewWord, tXfer, parkNow, tgtCmdWrite;
    logic [CBE_W-1:0] cbeForPar;
    logic             genOdd, chkOdd, chkArm_r;
    logic [AD_W-1:0]  adQ_r;
    logic [CBE_W-1:0] cbeQ_r;

    assign frameAct  = ~secFrameNIn;
    assign irdyAct   = ~secInitiatorReadyNIn;
    assign trdyAct   = ~secTargetReadyNIn;
    assign devselAct = ~secDeviceSelectNIn;
    assign stopAct   = ~secStopNIn;
    assign lockAct   = ~secLockNIn;
    assign grantAct  = ~busGrantN;
    assign busIdle   = ~frameAct & ~irdyAct;
    assign xfer      = irdyAct & trdyAct; // R3
    // Own address phase is excluded: we are not idle then
    assign addrPhase = frameAct & ~prevFrame_r & (mState_r == M_IDLE); // R1
    assign trdyOn    = (secTargetReadyNOeN == OE_DRIVE) && (secTargetReadyNOut == ASSERTED);

    ////////////////////////////////////////////////////////////////////////////
    // Master and target decisions
    assign mTake    = (mState_r == M_IDLE) & mstReq & grantAct & busIdle & (tState_r == T_IDLE);
    assign mTimeout = ((mState_r == M_ADDR) | (mState_r == M_DATA)) & ~devselSeen_r & ~devselAct
                      & (cnt_r == CNT_W'(TIMEOUT_CLKS - 1)); // R15
    assign mXfer    = (mState_r == M_DATA) & xfer; // R3
    assign mRetry   = (mState_r == M_DATA) & stopAct & ~trdyAct; // R16
    assign mEnd     = mTimeout | mRetry
                      | (mXfer & ((secFrameNOut == DEASSERTED) | stopAct)); // R12 R16
    assign tXfer    = (tState_r == T_DATA) & xfer; // R3
    assign parkNow  = (mNext == M_IDLE) & (tNext == T_IDLE) & grantAct & busIdle;

    always_comb begin
        mNext = mState_r;
        unique case (mState_r)
            M_IDLE: if (mTake) mNext = M_ADDR;
            M_ADDR: mNext = mTimeout ? M_TURN : M_DATA;
            M_DATA: begin
                if (mEnd) begin
                    mNext = M_TURN;
                end else if (mXfer) begin
                    mNext = M_LOAD;
                end
            end
            M_LOAD: mNext = M_DATA;
            M_TURN: mNext = M_IDLE;
        endcase
    end

    always_comb begin
        tNext = tState_r;
        unique case (tState_r)
            T_IDLE:   if (addrPhase) tNext = T_DECODE;
            T_DECODE: tNext = lockAct ? T_IDLE : T_CLAIM; // R18
            T_CLAIM:  tNext = tgtClaim ? T_DATA : T_IDLE;
            T_DATA:   if (tXfer && !frameAct) tNext = T_TURN;
            T_TURN:   tNext = T_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin // R20 R21
        if (!rst_n) begin
            mState_r    <= M_IDLE;
            tState_r    <= T_IDLE;
            prevFrame_r <= 1'b0;
        end else begin
            mState_r    <= mNext;
            tState_r    <= tNext;
            prevFrame_r <= frameAct;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Claim timeout: counts edges after our FRAME assertion
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r        <= '0;
            devselSeen_r <= 1'b0;
            mWrite_r     <= 1'b0;
            mLock_r      <= 1'b0;
        end else if (mTake) begin
            cnt_r        <= '0;
            devselSeen_r <= 1'b0;
            mWrite_r     <= mstWrite;
            mLock_r      <= mstLock;
        end else if (mState_r == M_ADDR || mState_r == M_DATA || mState_r == M_LOAD) begin
            if (cnt_r != '1) cnt_r <= cnt_r + 1'b1; // R21
            if (devselAct) devselSeen_r <= 1'b1; // R15
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Initiator control lines
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            secFrameNOut          <= DEASSERTED; // R19
            secFrameNOeN          <= OE_FLOAT;
            secInitiatorReadyNOut <= DEASSERTED;
            secInitiatorReadyNOeN <= OE_FLOAT;
            secLockNOut           <= DEASSERTED;
            secLockNOeN           <= OE_FLOAT;
        end else begin
            unique case (mNext)
                M_ADDR: begin
                    secFrameNOut          <= ASSERTED; // R1 R12
                    secFrameNOeN          <= OE_DRIVE;
                    secInitiatorReadyNOut <= DEASSERTED;
                    secInitiatorReadyNOeN <= OE_DRIVE;
                end
                M_DATA: begin
                    secInitiatorReadyNOut <= ASSERTED; // R14
                    if (mState_r != M_DATA) begin
                        secFrameNOut <= mstLast ? DEASSERTED : ASSERTED; // R12
                    end else if (stopAct) begin
                        secFrameNOut <= DEASSERTED; // R16
                    end
                    if (mState_r == M_ADDR && mLock_r) begin
                        secLockNOut <= ASSERTED; // R17
                        secLockNOeN <= OE_DRIVE;
                    end
                end
                M_LOAD: secInitiatorReadyNOut <= DEASSERTED;
                M_TURN: begin
                    // One clock of driven-high before release
                    secFrameNOut          <= DEASSERTED; // R13
                    secInitiatorReadyNOut <= DEASSERTED;
                    secLockNOut           <= DEASSERTED;
                end
                M_IDLE: begin
                    secFrameNOeN          <= OE_FLOAT; // R13
                    secInitiatorReadyNOeN <= OE_FLOAT;
                    secLockNOeN           <= OE_FLOAT;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Target control lines; STOP is only ever driven deasserted here
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            secTargetReadyNOut  <= DEASSERTED; // R19
            secTargetReadyNOeN  <= OE_FLOAT;
            secDeviceSelectNOut <= DEASSERTED;
            secDeviceSelectNOeN <= OE_FLOAT;
            secStopNOut         <= DEASSERTED;
            secStopNOeN         <= OE_FLOAT;
        end else begin
            secStopNOut <= DEASSERTED;
            unique case (tNext)
                T_DATA: begin
                    secDeviceSelectNOut <= ASSERTED;
                    secDeviceSelectNOeN <= OE_DRIVE;
                    secStopNOeN         <= OE_DRIVE;
                    secTargetReadyNOeN  <= OE_DRIVE;
                    secTargetReadyNOut  <= ((trdyOn && !xfer) || tgtReady) ? ASSERTED
                                                                           : DEASSERTED; // R14
                end
                T_TURN: begin
                    secTargetReadyNOut  <= DEASSERTED; // R13
                    secDeviceSelectNOut <= DEASSERTED;
                end
                default: begin
                    secTargetReadyNOeN  <= OE_FLOAT; // R13
                    secDeviceSelectNOeN <= OE_FLOAT;
                    secStopNOeN         <= OE_FLOAT;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AD and C/BE: master phases, target read data, or parking
    assign tNewWord = (tNext == T_DATA) & (~trdyOn | xfer);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            secAddrDataOut       <= AD_RESET; // R19
            secAddrDataOeN       <= OE_DRIVE;
            secCmdByteEnablesOut <= CBE_RESET;
            secCmdByteEnablesOeN <= OE_DRIVE;
        end else if (mNext == M_ADDR) begin
            secAddrDataOut       <= mstAddr; // R1
            secAddrDataOeN       <= OE_DRIVE;
            secCmdByteEnablesOut <= mstCmd; // R5
            secCmdByteEnablesOeN <= OE_DRIVE;
        end else if (mNext == M_DATA) begin
            // Held through the phase so write data stays stable under IRDY
            if (mState_r != M_DATA) begin
                secAddrDataOut       <= mstWrData; // R2
                secAddrDataOeN       <= mWrite_r ? OE_DRIVE : OE_FLOAT;
                secCmdByteEnablesOut <= mstByteEn; // R5
                secCmdByteEnablesOeN <= OE_DRIVE;
            end
        end else if (mNext == M_LOAD) begin
            secAddrDataOeN <= secAddrDataOeN;
        end else if (tNext == T_DATA && !tgtCmdWrite) begin
            if (tNewWord) secAddrDataOut <= tgtRdData;
            secAddrDataOeN       <= OE_DRIVE;
            secCmdByteEnablesOeN <= OE_FLOAT;
        end else if (parkNow) begin
            secAddrDataOut       <= AD_PARK; // R4
            secAddrDataOeN       <= OE_DRIVE;
            secCmdByteEnablesOut <= CBE_PARK; // R6
            secCmdByteEnablesOeN <= OE_DRIVE;
        end else begin
            secAddrDataOeN       <= OE_FLOAT;
            secCmdByteEnablesOeN <= OE_FLOAT;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Parity out: covers the cycle just ended, so it lags AD by one clock
    assign tgtCmdWrite = fwdCmd[CMD_WRITE_BIT];
    // When the initiator owns C/BE, parity must cover what it drove
    assign cbeForPar   = (secCmdByteEnablesOeN == OE_DRIVE) ? secCmdByteEnablesOut
                                                            : secCmdByteEnablesIn;

    even_parity #(.W(AD_W + CBE_W)) u_gen (
        .bits ({secAddrDataOut, cbeForPar}),
        .odd  (genOdd)
    );

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            secParityLineOut <= PAR_RESET; // R19
            secParityLineOeN <= OE_DRIVE;
        end else begin
            secParityLineOut <= genOdd; // R7 R10 R6
            secParityLineOeN <= secAddrDataOeN; // R11
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Parity check on received address, write data and master read data
    even_parity #(.W(AD_W + CBE_W + 1)) u_chk (
        .bits ({adQ_r, cbeQ_r, secParityLineIn}),
        .odd  (chkOdd)
    );

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            adQ_r    <= AD_RESET;
            cbeQ_r   <= CBE_RESET;
            chkArm_r <= 1'b0;
            parErr   <= 1'b0;
        end else begin
            adQ_r    <= secAddrDataIn;
            cbeQ_r   <= secCmdByteEnablesIn;
            chkArm_r <= addrPhase | (tXfer & tgtCmdWrite) | (mXfer & ~mWrite_r); // R8 R9
            parErr   <= chkArm_r & chkOdd; // R7
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // User-side strobes and captured data
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mstStart   <= 1'b0;
            mstXfer    <= 1'b0;
            mstRdData  <= AD_RESET;
            mstDone    <= 1'b0;
            mstAbort   <= 1'b0;
            mstStopped <= 1'b0;
        end else begin
            mstStart   <= mTake;
            mstXfer    <= mXfer; // R3
            mstDone    <= (mNext == M_TURN) && (mState_r != M_TURN);
            mstAbort   <= mTimeout; // R15
            mstStopped <= (mState_r == M_DATA) && stopAct && mEnd && !mTimeout; // R16
            if (mXfer) mstRdData <= secAddrDataIn;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fwdValid       <= 1'b0;
            fwdAddr        <= AD_RESET;
            fwdCmd         <= CBE_RESET;
            fwdLockRefused <= 1'b0;
            tgtWrValid     <= 1'b0;
            tgtWrData      <= AD_RESET;
            tgtWrByteEn    <= CBE_RESET;
        end else begin
            if (addrPhase) begin
                fwdAddr <= secAddrDataIn; // R1
                fwdCmd  <= secCmdByteEnablesIn; // R5
            end
            fwdValid       <= (tState_r == T_DECODE) && !lockAct; // R18
            fwdLockRefused <= (tState_r == T_DECODE) && lockAct; // R18
            tgtWrValid     <= tXfer && tgtCmdWrite;
            if (tXfer) begin
                tgtWrData   <= secAddrDataIn;
                tgtWrByteEn <= secCmdByteEnablesIn;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_xfer_needs_both: assert property (@(posedge sys_clk) disable iff (!rst_n) // R3
        mstXfer |-> $past(irdyAct && trdyAct))
        else $error("master transfer without both ready lines");

    a_park_drives_bus: assert property (@(posedge sys_clk) disable iff (!rst_n) // R4
        (mState_r == M_IDLE && tState_r == T_IDLE && grantAct && busIdle)
        |=> (secAddrDataOeN == OE_DRIVE) && (secCmdByteEnablesOeN == OE_DRIVE))
        else $error("idle granted bus not parked");

    a_par_even_sum: assert property (@(posedge sys_clk) disable iff (!rst_n) // R7
        ($past(secAddrDataOeN) == OE_DRIVE)
        |-> ^{$past(secAddrDataOut), $past(cbeForPar), secParityLineOut} == 1'b0)
        else $error("driven parity not even");

    a_par_float_lag: assert property (@(posedge sys_clk) disable iff (!rst_n) // R11
        $rose(secAddrDataOeN) |=> $rose(secParityLineOeN))
        else $error("parity did not float one clock after AD");

    a_frame_turn_high: assert property (@(posedge sys_clk) disable iff (!rst_n) // R13
        $rose(secFrameNOeN) |-> $past(secFrameNOut) && $past(secInitiatorReadyNOut))
        else $error("control floated without deasserted clock");

    a_irdy_held: assert property (@(posedge sys_clk) disable iff (!rst_n) // R14
        (mState_r == M_DATA && !secInitiatorReadyNOut && !trdyAct && !stopAct && !mTimeout)
        |=> !secInitiatorReadyNOut)
        else $error("initiator ready dropped mid phase");

    a_trdy_held: assert property (@(posedge sys_clk) disable iff (!rst_n) // R14
        (trdyOn && !irdyAct && tState_r == T_DATA) |=> trdyOn)
        else $error("target ready dropped mid phase");

    a_abort_five_clk: assert property (@(posedge sys_clk) disable iff (!rst_n) // R15
        (mState_r == M_ADDR && !devselAct) ##1 (!devselAct)[*4] |=> mstAbort)
        else $error("no master abort after claim timeout");

    a_lock_after_addr: assert property (@(posedge sys_clk) disable iff (!rst_n) // R17
        (mState_r == M_ADDR && mLock_r && !mTimeout)
        |=> (secLockNOut == ASSERTED) && (secLockNOeN == OE_DRIVE))
        else $error("lock not asserted after address phase");

    a_lock_not_fwd: assert property (@(posedge sys_clk) disable iff (!rst_n) // R18
        (tState_r == T_DECODE && lockAct) |=> !fwdValid && fwdLockRefused ##1 !fwdValid)
        else $error("locked transaction forwarded upstream");

endmodule : pci_secondary_bus_port

// ===== tb/pci_tgt_model.sv
// Purpose: Behavioural target answering the bridge on the secondary bus.
// Assumes: One word per transaction; never signals STOP.
// Notes:   Enables low = driving; slow adds one decode clock before claim.
`timescale 1ns/100ps
module pci_tgt_model (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        frameN,
    input  wire logic        irdyN,
    input  wire logic [31:0] adBus,
    input  wire logic [3:0]  cbeBus,
    input  wire logic        claimEn,
    input  wire logic        slow,
    input  wire logic [31:0] rdWord,
    output logic             selN,
    output logic             ctlOeN,
    output logic      [31:0] adOut,
    output logic             adOeN,
    output logic             parOut,
    output logic             parOeN
);
    logic [1:0] st_r;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r   <= 2'h0;
            selN   <= 1'h1;
            ctlOeN <= 1'h1;
            adOeN  <= 1'h1;
            parOeN <= 1'h1;
        end else begin
            parOeN <= adOeN;
            parOut <= ^{adBus, cbeBus};
            adOut  <= rdWord;
            case (st_r)
                2'h0: if (!frameN && claimEn) begin
                    ctlOeN <= 1'h0;
                    selN   <= slow;
                    adOeN  <= cbeBus[0];
                    st_r   <= slow ? 2'h3 : 2'h1;
                end
                2'h3: begin
                    selN <= 1'h0;
                    st_r <= 2'h1;
                end
                2'h1: if (!irdyN && !selN && frameN) begin
                    selN  <= 1'h1;
                    adOeN <= 1'h1;
                    st_r  <= 2'h2;
                end
                // Held high one clock before floating
                default: begin
                    ctlOeN <= 1'h1;
                    st_r   <= 2'h0;
                end
            endcase
        end
    end
endmodule : pci_tgt_model

// ===== tb/tb_top.sv
// Purpose: Self-checking bench for the master side of the secondary port.
// Assumes: Pull-ups on control lines; a released AD bus reads as inverted.
// Notes:   Target-side user inputs are tied off; the model answers instead.
`timescale 1ns/100ps
module tb_top import pci_sec_pkg::*; ;
    logic [AD_W-1:0]  secAddrDataIn, secAddrDataOut, mstAddr, mstWrData, mstRdData, fwdAddr;
    logic [AD_W-1:0]  tgtRdData, tgtWrData, adOut, adLast, rdWord, xferAd;
    logic [CBE_W-1:0] secCmdByteEnablesIn, secCmdByteEnablesOut, mstCmd, mstByteEn, fwdCmd;
    logic [CBE_W-1:0] tgtWrByteEn;
    logic sys_clk, rst_n, secAddrDataOeN, secCmdByteEnablesOeN, secParityLineIn;
    logic secParityLineOut, secParityLineOeN, secFrameNIn, secFrameNOut, secFrameNOeN;
    logic secInitiatorReadyNIn, secInitiatorReadyNOut, secInitiatorReadyNOeN;
    logic secTargetReadyNIn, secTargetReadyNOut, secTargetReadyNOeN, secDeviceSelectNIn;
    logic secDeviceSelectNOut, secDeviceSelectNOeN, secStopNIn, secStopNOut, secStopNOeN;
    logic secLockNIn, secLockNOut, secLockNOeN, busGrantN, mstReq, mstWrite, mstLock;
    logic mstLast, mstStart, mstXfer, mstDone, mstAbort, mstStopped, fwdValid;
    logic fwdLockRefused, tgtClaim, tgtReady, tgtWrValid, parErr;
    logic claimEn, slow, selN, ctlOeN, adOeN, parOut, parOeN;
    logic [36:0] expQ[$];
    int numErrors, nTests;
    ////////////////////////////////////////////////////////////////////////////////
    assign secFrameNIn = secFrameNOeN | secFrameNOut;
    assign secInitiatorReadyNIn = secInitiatorReadyNOeN | secInitiatorReadyNOut;
    assign secTargetReadyNIn = !secTargetReadyNOeN ? secTargetReadyNOut : (ctlOeN | selN);
    assign secDeviceSelectNIn = !secDeviceSelectNOeN ? secDeviceSelectNOut : (ctlOeN | selN);
    assign secStopNIn = secStopNOeN | secStopNOut;
    assign secLockNIn = secLockNOeN | secLockNOut;
    assign secAddrDataIn = !secAddrDataOeN ? secAddrDataOut : !adOeN ? adOut : ~adLast;
    assign secCmdByteEnablesIn = secCmdByteEnablesOut ^ {CBE_W{secCmdByteEnablesOeN}};
    assign secParityLineIn = !secParityLineOeN ? secParityLineOut : !parOeN ? parOut : ~adLast[0];
    pci_secondary_bus_port #(.TIMEOUT_CLKS(DEVSEL_TIMEOUT_CLKS)) i_dut (.*);
    pci_tgt_model i_tgt (.sys_clk, .rst_n, .frameN(secFrameNIn), .irdyN(secInitiatorReadyNIn),
        .adBus(secAddrDataIn), .cbeBus(secCmdByteEnablesIn), .claimEn, .slow, .rdWord,
        .selN, .ctlOeN, .adOut, .adOeN, .parOut, .parOeN);
    initial begin
        sys_clk = 1'h0;
        forever #(CLK_PERIOD_NS / 2.0) sys_clk = ~sys_clk;
    end
    task automatic check(input logic [36:0] e, input logic [36:0] g);
        nTests++;
        if (g !== e) begin
            numErrors++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : check
    task automatic print_verdict;
        $display("comparisons=%0d mismatches=%0d", nTests, numErrors);
        if (numErrors == 0 && nTests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    task automatic waitFor(input logic which);
        int n;
        n = 0;
        do @(posedge sys_clk); while ((which ? !(mstDone | mstAbort) : !mstStart) && ++n < 50);
        if (n >= 50) begin
            numErrors++;
            print_verdict();
        end
    endtask : waitFor
    // Single-word transfer; cl = 0 leaves it unclaimed to force an abort
    task automatic xact(input logic wr, input logic cl, input logic sl);
        logic [5:0] g;
        {claimEn, slow, mstWrite, mstReq, mstLock} <= {cl, sl, wr, 1'h1, sl | !cl};
        {rdWord, mstWrData, mstAddr} <= {$urandom, $urandom, $urandom};
        mstByteEn <= 4'($urandom);
        mstCmd <= {3'h3, wr};
        waitFor(1'h0);
        mstReq <= 1'h0;
        expQ.push_back({3'h0, wr, !cl, cl ? (wr ? mstWrData : rdWord) : 32'h0});
        check({mstCmd, ASSERTED, mstAddr}, {secCmdByteEnablesIn, secFrameNIn, secAddrDataIn});
        waitFor(1'h1);
        g[5:2] = {secFrameNOeN, secFrameNOut, secAddrDataOeN, secParityLineOeN};
        @(posedge sys_clk);
        g[1:0] = {secFrameNOeN, secParityLineOeN};
        if (cl) check({OE_DRIVE, DEASSERTED, OE_FLOAT, !wr, OE_FLOAT, OE_FLOAT}, 37'(g));
        repeat (2) @(posedge sys_clk);
        $display("test wr=%0d claim=%0d slow=%0d done", wr, cl, sl);
    endtask : xact
    // Watcher: oldest note per result
    always @(posedge sys_clk) begin
        adLast <= secAddrDataIn;
        if (!secInitiatorReadyNIn && !secTargetReadyNIn) xferAd <= secAddrDataIn;
        if (parErr) check(37'h0, 37'h1);
        if ((mstXfer || mstAbort) && expQ.size() > 0) begin
            check(expQ[0], {3'h0, expQ[0][33], mstAbort,
                mstAbort ? 32'h0 : expQ[0][33] ? xferAd : mstRdData});
            void'(expQ.pop_front());
        end
    end
    initial begin
        {rst_n, busGrantN, mstReq, mstWrite, mstLock, tgtClaim, tgtReady, claimEn, slow} = '0;
        {mstCmd, mstAddr, mstWrData, mstByteEn, tgtRdData, rdWord, adLast, xferAd} = '0;
        mstLast = 1'h1;
        void'($urandom(32'h9051));
        repeat (16) @(posedge sys_clk);
        check({OE_FLOAT, OE_FLOAT, OE_DRIVE, AD_RESET},
            {secFrameNOeN, secInitiatorReadyNOeN, secAddrDataOeN, secAddrDataOut});
        rst_n <= 1'h1;
        repeat (4) @(posedge sys_clk);
        check({OE_DRIVE, OE_DRIVE, OE_DRIVE, AD_PARK},
            {secAddrDataOeN, secCmdByteEnablesOeN, secParityLineOeN, secAddrDataOut});
        for (int k = 0; k < 6; k++) xact(k[0], k < 4, k[1]);
        repeat (4) @(posedge sys_clk);
        check(37'h0, 37'(expQ.size()));
        print_verdict();
    end
endmodule : tb_top
